/* File: bench/ext_mem_clock_strobe_select_tb.sv */
// Self-checking testbench of the memory clock/strobe block.
`timescale 1ns/1ps
`include "emif_clk_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, (a), (b)); end end
module ext_mem_clock_strobe_select_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [`APB_ADDR_W-1:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic pready, pslverr, e, fclk, dclk, eclk, rdy, hreq, hack, breq, oe;
   logic strobe_n, fifo_n, cke, pdt_n, hold_want = 1'b0;
   logic [1:0] straps = 2'h0;
   logic [3:0] ce_n;
   logic [7:0] dly = 8'h00;
   int n_mismatch = 0, total_checks = 0, p;
   int base[4] = '{8, 4, 6, 8};
   int mul[4] = '{1, 2, 4, 4};
   logic [1:0] srcx[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
   logic [5:0] ck_ctrl[4] = '{6'h18, 6'h08, 6'h20, 6'h00};
   logic ck_exp[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

   ext_mem_clock_strobe_select u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_mem_input_clock(eclk),
      .clock_source_strap_pins(straps), .ext_mem_full_rate_clock_out(fclk),
      .ext_mem_divided_clock_out(dclk), .memory_space_enable_n(ce_n),
      .shared_strobe_n(strobe_n), .space3_fifo_output_enable_n(fifo_n),
      .sdram_clock_enable_out(cke), .peripheral_direct_transfer_n(pdt_n),
      .bus_outputs_oe(oe), .async_ready_in(rdy), .host_bus_hold_request(hreq),
      .host_bus_hold_ack(hack), .bus_request_out(breq));
   ext_mem_partner u_far (.pclk(pclk), .presetn(presetn), .hold_want(hold_want),
      .ready_delay(dly), .memory_space_enable_n(ce_n), .ext_mem_input_clock(eclk),
      .async_ready_in(rdy), .host_bus_hold_request(hreq));

   // ==========================================================
   // Clock, watchdog and per-cycle checks
   always #12.5 pclk = ~pclk;
   initial begin
      #(25 * 30000);
      n_mismatch++;
      end_of_test();
   end
   // The host must never see its acknowledge while the device still drives the bus.
   always @(posedge pclk) begin
      if (presetn === 1'b1) begin
         `CHK(hack & oe, 1'b0)
         `CHK($countones(~ce_n) > 1, 1'b0)
      end
   end

   // ==========================================================
   // Tasks
   // One APB transfer; an idle edge follows so that psel is never rewritten in one step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count is assumed here; only the watchdog may end this wait.
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic do_reset(input logic [1:0] s);
      presetn <= 1'b0; straps <= s;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   // Counts pclk cycles between the second and third rise, skipping any phase-in.
   task automatic period(input bit div, output int q);
      int n, r;
      logic pv, cv;
      n = 0; r = 0; pv = 1'b1;
      while (r < 3 && n < 400) begin
         @(posedge pclk); n++;
         cv = div ? dclk : fclk;
         if (cv === 1'b1 && pv === 1'b0) begin r++; if (r == 2) n = 0; end
         pv = cv;
      end
      q = n;
   endtask
   // Starts one access, then watches the memory pins until the bus is released.
   task automatic run_acc(input logic [1:0] sp, input logic as, rd, pd, role,
                          input logic [7:0] dl, input logic hq);
      int oc, st;
      logic br, fs, ps;
      oc = 0; st = 0; br = 0; fs = 0; ps = 0; dly <= dl;
      apb(1'b1, `OFS_CTRL, {26'h0, 6'h08 | role});
      apb(1'b1, `OFS_ACC_ADDR, {`SPACE_REGION, sp, 28'h0000120});
      apb(1'b1, `OFS_ACC_CMD, {28'h0, pd, rd, as, 1'b1});
      hold_want <= hq;
      for (int i = 0; i < 300; i++) begin
         @(posedge pclk);
         if (breq === 1'b1) br = 1;
         if (oe === 1'b1) begin
            oc++;
            `CHK(ce_n, ~(4'h1 << sp))
            if (strobe_n === 1'b0) st++;
            if (fifo_n === 1'b0) fs = 1;
            if (pdt_n === 1'b0) ps = 1;
         end else if (oc > 0) break;
      end
      `CHK(oc != 0, 1'b1)
      `CHK(br, 1'b1)
      `CHK(fs, sp == 2'h3 && !as && rd)
      `CHK(ps, pd)
      if (role) `CHK(st, rd ? oc : 0)
      else `CHK(st == oc, !as)
      if (as) `CHK(oc > dl, 1'b1)
      repeat (2) @(posedge pclk);
      `CHK(breq, 1'b0)
   endtask
   task automatic test_done(input string nm);
      $display("test %s finished", nm);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      do_reset(2'h1);
      apb(1'b0, `OFS_CTRL, 32'h0);
      `CHK(d[5:0], 6'h08)
      `CHK(cke, 1'b1)
      apb(1'b0, 8'h10, 32'h0);
      `CHK(e, 1'b1)
      test_done("reset");
      // Every strap code and every divide ratio, including the spare ones.
      for (int s = 0; s < 4; s++) begin
         do_reset(s[1:0]);
         apb(1'b0, `OFS_STATUS, 32'h0);
         `CHK(d[2:0], {1'b1, srcx[s]})
         for (int r = 0; r < 4; r++) begin
            apb(1'b1, `OFS_CTRL, 32'h08 | (r << 1));
            period(1'b0, p);
            `CHK(p, base[s])
            period(1'b1, p);
            `CHK(p, base[s] * mul[r])
         end
      end
      test_done("clocks");
      do_reset(2'h1);
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, `OFS_CTRL, {26'h0, ck_ctrl[k]});
         repeat (2) @(posedge pclk);
         `CHK(cke, ck_exp[k])
      end
      test_done("clock_enable");
      run_acc(2'h3, 1'b0, 1'b1, 1'b0, 1'b0, 8'd0, 1'b0);
      run_acc(2'h3, 1'b0, 1'b1, 1'b0, 1'b1, 8'd0, 1'b0);
      run_acc(2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 8'd10, 1'b0);
      run_acc(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 8'd12, 1'b0);
      run_acc(2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 8'd10, 1'b0);
      run_acc(2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 8'd10, 1'b0);
      run_acc(2'h2, 1'b0, 1'b0, 1'b0, 1'b1, 8'd0, 1'b0);
      apb(1'b1, `OFS_ACC_ADDR, 32'h1000_0000);
      apb(1'b1, `OFS_ACC_CMD, 32'h1);
      apb(1'b0, `OFS_STATUS, 32'h0);
      `CHK(d[6], 1'b1)
      `CHK(breq, 1'b0)
      test_done("access");
      // A hold request that arrives mid-access is granted only after the bus is released.
      run_acc(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 8'd20, 1'b1);
      for (int i = 0; i < 10 && hack !== 1'b1; i++) @(posedge pclk);
      `CHK(hack, 1'b1)
      `CHK(oe, 1'b0)
      hold_want <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK(hack, 1'b0)
      test_done("hold");
      end_of_test();
   end
endmodule // ext_mem_clock_strobe_select_tb

/* File: bench/ext_mem_partner.sv */
// Far-side model: external oscillator, an asynchronous memory and a bus-holding host.
`timescale 1ns/1ps
module ext_mem_partner (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench commands
   input wire logic hold_want,
   input wire logic [7:0] ready_delay,
   // Device pins
   input wire logic [3:0] memory_space_enable_n,
   output logic ext_mem_input_clock,
   output logic async_ready_in,
   output logic host_bus_hold_request
);
   logic [1:0] osc_cnt = 2'h0;
   logic [7:0] wait_cnt;

   // ==========================================================
   // Oscillator
   // Free running, toggling every fourth pclk, so one period is eight pclk cycles.
   initial ext_mem_input_clock = 1'b0;
   always @(posedge pclk) begin
      osc_cnt <= osc_cnt + 2'h1;
      if (osc_cnt == 2'h3) begin
         ext_mem_input_clock <= ~ext_mem_input_clock;
      end
   end

   // ==========================================================
   // Memory and host
   // The memory holds ready low for ready_delay cycles once selected; the line has a
   // pull-up, so it reads high whenever no space is selected.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 8'h00;
         host_bus_hold_request <= 1'b0;
      end else begin
         host_bus_hold_request <= hold_want;
         if (&memory_space_enable_n) begin
            wait_cnt <= 8'h00;
         end else if (wait_cnt != 8'hff) begin
            wait_cnt <= wait_cnt + 8'h01;
         end
      end
   end
   assign async_ready_in = (&memory_space_enable_n) | (wait_cnt >= ready_delay);
endmodule // ext_mem_partner

/* File: design/emif_clk_defines.svh */
// Offsets, field positions, reset values and timing counts of the memory clock/strobe block.
`ifndef EMIF_CLK_DEFINES_SVH
`define EMIF_CLK_DEFINES_SVH

// =============================================================
// Register map (byte addresses on the APB port)
`define APB_ADDR_W 8
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACC_ADDR 8'h08
`define OFS_ACC_CMD 8'h0c

// =============================================================
// Field positions and reset values
`define CTRL_W 6
`define CTRL_RESET 6'h08
`define CMD_START_BIT 0
`define CMD_ASYNC_BIT 1
`define CMD_READ_BIT 2
`define CMD_PDT_BIT 3
`define CMD_W 3
`define ACC_ADDR_RESET 32'h0000_0000
`define SPACE_REGION 2'h2
`define SPACE_FIFO 2'h3

// =============================================================
// Clock source straps, divide ratios and CPU clock divisors
`define STRAP_CPU_DIV4 2'h1
`define STRAP_CPU_DIV6 2'h2
`define RATIO_BY1 2'h0
`define RATIO_BY2 2'h1
`define RATIO_BY4 2'h2
`define CPU_DIV4 4
`define CPU_DIV6 6

`endif

/* File: design/emif_clk_pkg.sv */
// Types shared by the memory clock/strobe block.
package emif_clk_pkg;

   // =============================================================
   // Clock source chosen by the straps.
   typedef enum logic [1:0] {SRC_EXT, SRC_DIV4, SRC_DIV6} source_e;

   // =============================================================
   // External access sequencer states.
   typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_WAIT, ST_DONE, ST_HOLD} access_e;

   // =============================================================
   // Control register layout, low bit first at the bottom.
   typedef struct packed {
      logic gpo_value;
      logic self_refresh;
      logic sdram_fitted;
      logic [1:0] ratio;
      logic strobe_role_select;
   } ctrl_s;

   // Flags of a queued external access.
   typedef struct packed {
      logic pdt;
      logic read;
      logic async;
   } cmd_s;

endpackage

/* File: design/ext_mem_clock_strobe_select.sv */
// Clock select, strobe muxing and bus hold handshake of the wide external memory port.
//
// Function
// - Straps pick ext clock, CPU/4 or CPU/6.
// - Unrequested strap code defaults to external clock.
// - Divided clock runs at input by 1/2/4.
// - Full rate clock equals selected input clock.
// - Role field picks address strobe or read enable.
// - Clock enable drives self-refresh, else plain output.
// - Space three gets its own FIFO output enable for synchronous reads.
// - Host hold request answered by hold acknowledge.
// - Bus request output shows wanted bus access.
// - Ready input paces asynchronous accesses.
// - Peripheral direct transfer output during flagged access.
// - Space enables decoded from top address bits.
// - At most one space enable per access.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "emif_clk_defines.svh"
module ext_mem_clock_strobe_select (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [`APB_ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock pins
   input wire logic ext_mem_input_clock,
   input wire logic [1:0] clock_source_strap_pins,
   output logic ext_mem_full_rate_clock_out,
   output logic ext_mem_divided_clock_out,
   // Memory control pins
   output logic [3:0] memory_space_enable_n,
   output logic shared_strobe_n,
   output logic space3_fifo_output_enable_n,
   output logic sdram_clock_enable_out,
   output logic peripheral_direct_transfer_n,
   output logic bus_outputs_oe,
   input wire logic async_ready_in,
   // Bus arbitration pins
   input wire logic host_bus_hold_request,
   output logic host_bus_hold_ack,
   output logic bus_request_out
);
   import emif_clk_pkg::*;

   emif_clk_pkg::source_e src;
   emif_clk_pkg::access_e state;
   emif_clk_pkg::access_e next_state;
   emif_clk_pkg::ctrl_s ctrl;
   emif_clk_pkg::cmd_s cmd;
   logic strap_valid;
   logic ext_q;
   logic ext_prev;
   logic div4_rise;
   logic div4_fall;
   logic div6_rise;
   logic div6_fall;
   logic sel_rise;
   logic sel_fall;
   logic phase;
   logic next_full;
   logic next_divided;
   logic [31:0] acc_addr;
   logic [1:0] acc_space;
   logic pending;
   logic acc_err;
   logic next_pending;
   logic next_in_access;
   logic [3:0] next_ce_n;

   // =============================================================
   // Strap capture
   // The straps are caught on the first edge after release, never by the reset itself.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_valid <= 1'b0;
         src <= SRC_EXT;
      end else if (!strap_valid) begin
         strap_valid <= 1'b1;
         if (clock_source_strap_pins == `STRAP_CPU_DIV4) begin
            src <= SRC_DIV4;
         end else if (clock_source_strap_pins == `STRAP_CPU_DIV6) begin
            src <= SRC_DIV6;
         end else begin
            src <= SRC_EXT;
         end
      end
   end

   // =============================================================
   // Input clock sources
   tick_divider #(.DIV(`CPU_DIV4)) u_div4 (
      .pclk(pclk),
      .presetn(presetn),
      .run(strap_valid),
      .rise(div4_rise),
      .fall(div4_fall)
   );

   tick_divider #(.DIV(`CPU_DIV6)) u_div6 (
      .pclk(pclk),
      .presetn(presetn),
      .run(strap_valid),
      .rise(div6_rise),
      .fall(div6_fall)
   );

   // The pin is synchronous, so plain edge detection is safe; it limits it to at most pclk/2.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         ext_q <= ext_mem_input_clock;
         ext_prev <= ext_q;
      end
   end

   // Selected source as rising and falling enable pulses.
   assign sel_rise = strap_valid && ((src == SRC_EXT) ? (ext_q && !ext_prev) :
                     (src == SRC_DIV4) ? div4_rise : div6_rise);
   assign sel_fall = strap_valid && ((src == SRC_EXT) ? (!ext_q && ext_prev) :
                     (src == SRC_DIV4) ? div4_fall : div6_fall);

   // =============================================================
   // Output clocks
   // Ratio code 3 is treated as divide by four rather than stopping the clock.
   assign next_full = sel_rise ? 1'b1 : (sel_fall ? 1'b0 : ext_mem_full_rate_clock_out);
   assign next_divided = (ctrl.ratio == `RATIO_BY1) ? next_full :
                         (sel_rise && (ctrl.ratio == `RATIO_BY2 || phase)) ?
                         !ext_mem_divided_clock_out : ext_mem_divided_clock_out;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_mem_full_rate_clock_out <= 1'b0;
         ext_mem_divided_clock_out <= 1'b0;
         phase <= 1'b0;
      end else begin
         ext_mem_full_rate_clock_out <= next_full;
         ext_mem_divided_clock_out <= next_divided;
         phase <= sel_rise ? !phase : phase;
      end
   end

   // =============================================================
   // APB slave: zero wait states, pready is a one-cycle pulse in the access phase.
   logic apb_setup;
   logic apb_write;
   logic mapped;
   logic cmd_start;
   logic cmd_region_ok;
   logic [31:0] rd_mux;

   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pready && pwrite;
   assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
                   (paddr == `OFS_ACC_ADDR) || (paddr == `OFS_ACC_CMD);
   assign cmd_start = apb_write && (paddr == `OFS_ACC_CMD) && pwdata[`CMD_START_BIT] &&
                      !pending && (state == ST_IDLE);
   assign cmd_region_ok = (acc_addr[31:30] == `SPACE_REGION);
   assign rd_mux = (paddr == `OFS_CTRL) ? {26'h0, ctrl} :
                   (paddr == `OFS_STATUS) ? {24'h0, pending, acc_err, state != ST_IDLE,
                                             host_bus_hold_ack, bus_request_out,
                                             strap_valid, src} :
                   (paddr == `OFS_ACC_ADDR) ? acc_addr :
                   (paddr == `OFS_ACC_CMD) ? {28'h0, cmd, 1'b0} : 32'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup && !mapped;
         prdata <= (apb_setup && !pwrite) ? rd_mux : 32'h0;
      end
   end

   // Register writes; the address is frozen while an access is queued or running.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
         acc_addr <= `ACC_ADDR_RESET;
         cmd <= '0;
         acc_err <= 1'b0;
      end else begin
         if (apb_write && paddr == `OFS_CTRL) begin
            ctrl <= pwdata[`CTRL_W-1:0];
         end
         if (apb_write && paddr == `OFS_ACC_ADDR && !pending && state == ST_IDLE) begin
            acc_addr <= pwdata;
         end
         if (cmd_start) begin
            cmd <= pwdata[`CMD_PDT_BIT:`CMD_ASYNC_BIT];
            acc_err <= !cmd_region_ok;
         end
      end
   end

   // =============================================================
   // Access sequencer
   assign acc_space = acc_addr[29:28];

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (host_bus_hold_request) begin
               next_state = ST_HOLD;
            end else if (pending) begin
               next_state = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (sel_rise) begin
               next_state = cmd.async ? ST_WAIT : ST_DONE;
            end
         end
         ST_WAIT: begin
            if (async_ready_in) begin
               next_state = ST_DONE;
            end
         end
         ST_DONE: next_state = ST_IDLE;
         ST_HOLD: begin
            if (!host_bus_hold_request) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   // A queued access waits behind a host hold; the bus request shows it is waiting.
   assign next_pending = (cmd_start && cmd_region_ok) ? 1'b1 :
                         (next_state == ST_DONE) ? 1'b0 : pending;
   assign next_in_access = (next_state == ST_STROBE) || (next_state == ST_WAIT);

   // One enable per space, so no two can ever be low together.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_space
         assign next_ce_n[gi] = !(next_in_access && acc_space == 2'(gi));
      end
   endgenerate

   // Pin drivers follow the next state, so each pin but the clock enable is a flop aligned with the state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         pending <= 1'b0;
         memory_space_enable_n <= 4'hf;
         shared_strobe_n <= 1'b1;
         space3_fifo_output_enable_n <= 1'b1;
         peripheral_direct_transfer_n <= 1'b1;
         bus_outputs_oe <= 1'b0;
         host_bus_hold_ack <= 1'b0;
         bus_request_out <= 1'b0;
         sdram_clock_enable_out <= 1'b1;
      end else begin
         state <= next_state;
         pending <= next_pending;
         memory_space_enable_n <= next_ce_n;
         shared_strobe_n <= ctrl.strobe_role_select ? !(next_in_access && cmd.read) :
                            (next_state != ST_STROBE);
         space3_fifo_output_enable_n <= !(next_in_access && cmd.read && !cmd.async &&
                                          acc_space == `SPACE_FIFO);
         peripheral_direct_transfer_n <= !(next_in_access && cmd.pdt);
         bus_outputs_oe <= next_in_access;
         host_bus_hold_ack <= (next_state == ST_HOLD);
         bus_request_out <= next_pending;
         sdram_clock_enable_out <= ctrl.sdram_fitted ? !ctrl.self_refresh : ctrl.gpo_value;
      end
   end

   // =============================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_STRAP_DIV6: assert property ($rose(strap_valid) |->
      ((src == SRC_DIV6) == ($past(clock_source_strap_pins) == `STRAP_CPU_DIV6)))
      else $error("clock source does not match CPU/6 strap");
   AST_STRAP_DEFAULT: assert property ($rose(strap_valid) &&
      $past(clock_source_strap_pins) != `STRAP_CPU_DIV4 &&
      $past(clock_source_strap_pins) != `STRAP_CPU_DIV6 |-> src == SRC_EXT)
      else $error("unrequested strap code did not select external clock");
   AST_FULL_RATE: assert property ((sel_rise |=> ext_mem_full_rate_clock_out) and
      (sel_fall |=> !ext_mem_full_rate_clock_out))
      else $error("full rate clock missed an input edge");
   AST_DIV_BY2: assert property (sel_rise && ctrl.ratio == `RATIO_BY2 |=>
      ext_mem_divided_clock_out != $past(ext_mem_divided_clock_out))
      else $error("divide by two clock did not toggle");
   AST_DIV_BY1: assert property (ctrl.ratio == `RATIO_BY1 &&
      $past(ctrl.ratio) == `RATIO_BY1 |-> ext_mem_divided_clock_out == ext_mem_full_rate_clock_out)
      else $error("divide by one clock differs from full rate clock");
   AST_STROBE_ROLE: assert property (!shared_strobe_n && !ctrl.strobe_role_select &&
      !$past(ctrl.strobe_role_select) |-> state == ST_STROBE)
      else $error("address strobe outside strobe cycle");
   AST_CKE: assert property ($past(ctrl.sdram_fitted) && $past(ctrl.self_refresh) |->
      !sdram_clock_enable_out)
      else $error("clock enable high during self-refresh");
   AST_FIFO_OE: assert property (!space3_fifo_output_enable_n |->
      memory_space_enable_n == 4'h7)
      else $error("FIFO output enable without space three");
   AST_ONE_SPACE: assert property ($countones(~memory_space_enable_n) <= 1)
      else $error("more than one space enable asserted");
   AST_DECODE: assert property (state == ST_STROBE |->
      !memory_space_enable_n[acc_space] && acc_addr[31:30] == `SPACE_REGION)
      else $error("space enable does not match address");
   AST_READY_WAIT: assert property (state == ST_WAIT && !async_ready_in |=>
      state == ST_WAIT && bus_outputs_oe)
      else $error("asynchronous access ended without ready");
   AST_HOLD_RELEASE: assert property ($rose(host_bus_hold_ack) |->
      !bus_outputs_oe && $past(!bus_outputs_oe) && !$past(host_bus_hold_ack))
      else $error("hold acknowledged while bus still driven");
   AST_HOLD_ACK: assert property (state == ST_IDLE && host_bus_hold_request |=>
      host_bus_hold_ack)
      else $error("idle hold request not acknowledged");
   AST_BUS_REQ: assert property ($rose(pending) |-> bus_request_out)
      else $error("bus request missing for queued access");
   AST_PDT: assert property (!peripheral_direct_transfer_n |-> bus_outputs_oe)
      else $error("peripheral transfer outside an access");

   COV_HOLD: cover property ($rose(host_bus_hold_ack));
   COV_ASYNC_WAIT: cover property (state == ST_WAIT ##1 state == ST_WAIT ##1 state == ST_DONE);
   COV_SYNC_SPACE3: cover property (!space3_fifo_output_enable_n);
   COV_DIV4: cover property (ctrl.ratio == `RATIO_BY4 && sel_rise && phase);

endmodule // ext_mem_clock_strobe_select

/* File: design/tick_divider.sv */
// Divides the CPU clock into rising and falling half-period enable pulses.
`timescale 1ns/1ps
module tick_divider #(
   parameter int DIV = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   // Enable pulses
   output logic rise,
   output logic fall
);

   localparam int CW = $clog2(DIV);

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;

   // =============================================================
   // Counter wraps at DIV so the derived clock has an even duty where DIV is even.
   assign next_cnt = (cnt == CW'(DIV - 1)) ? '0 : cnt + CW'(1);
   assign rise = run && (cnt == '0);
   assign fall = run && (cnt == CW'(DIV / 2));

   // Count only while running so the first edge lands at a known phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= '0;
      end else if (run) begin
         cnt <= next_cnt;
      end
   end

endmodule // tick_divider
